// ===== logic/osr_serializer.sv
`include "osr_map.svh"
`default_nettype none
module osr_serializer #(
	parameter int CHANNELS = 8
) (
	input  wire logic                          i_clock,
	input  wire logic                          i_rstn,
	input  wire osr_pkg::osr_pins_t            i_pins,
	input  wire osr_pkg::osr_word_t [7:0]      i_parallel_word_in,
	output var osr_pkg::osr_frame_t [7:0]      o_serial_out,
	output logic [7:0]                         o_serial_oe_n,
	output logic                               o_frame_strobe,
	input  wire logic [3:0]                    i_s_axi_awaddr,
	input  wire logic                          i_s_axi_awvalid,
	output logic                               o_s_axi_awready,
	input  wire logic [31:0]                   i_s_axi_wdata,
	input  wire logic [3:0]                    i_s_axi_wstrb,
	input  wire logic                          i_s_axi_wvalid,
	output logic                               o_s_axi_wready,
	output logic [1:0]                         o_s_axi_bresp,
	output logic                               o_s_axi_bvalid,
	input  wire logic                          i_s_axi_bready,
	input  wire logic [3:0]                    i_s_axi_araddr,
	input  wire logic                          i_s_axi_arvalid,
	output logic                               o_s_axi_arready,
	output logic [31:0]                        o_s_axi_rdata,
	output logic [1:0]                         o_s_axi_rresp,
	output logic                               o_s_axi_rvalid,
	input  wire logic                          i_s_axi_rready
);
	import osr_pkg::*;

	function automatic osr_reg_t osr_decode(input logic [3:0] addr);
		case (addr)
			`OSR_ADDR_STATUS: osr_decode = OSR_REG_STATUS;
			`OSR_ADDR_CTRL:   osr_decode = OSR_REG_CTRL;
			default:          osr_decode = OSR_REG_NONE;
		endcase
	endfunction

	function automatic logic [7:0] osr_test_mask(input logic act, input logic [3:0] sel);
		logic [7:0] m;
		m = 8'h00;
		if (act) begin
			if (sel == `OSR_SEL_ALL) begin
				m = 8'hFF;
			end else if (sel < `OSR_SEL_ALL) begin
				m[sel[2:0]] = 1'b1;
			end
		end
		// codes above eight leave the mask empty
		return m;
	endfunction

	function automatic osr_prbs_t osr_prbs_step(input logic [14:0] s);
		osr_prbs_t r;
		logic [14:0] t;
		t = s;
		r.bits = 10'h000;
		for (int i = 0; i < 10; i++) begin
			r.bits[i] = t[14];
			t = {t[13:0], t[14] ^ t[13]};
		end
		r.state = t;
		return r;
	endfunction

	// two-stage capture of every pin; select resets to ones like its pull-up
	osr_pins_t            pins1_q;
	osr_pins_t            pins2_q;
	osr_word_t [7:0]      word1_q;
	osr_word_t [7:0]      word2_q;
	logic                 txc_prev_q;
	logic                 tx_rise;

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			pins1_q <= '0;
			pins2_q <= '0;
			pins1_q.self_test_select <= `OSR_SEL_RESET;
			pins2_q.self_test_select <= `OSR_SEL_RESET;
		end else begin
			pins1_q <= i_pins;
			pins2_q <= pins1_q;
		end
	end

	// data passes the same two stages as the clock, so a word stays aligned to its edge
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			word1_q <= '0;
			word2_q <= '0;
		end else begin
			word1_q <= i_parallel_word_in;
			word2_q <= word1_q;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			txc_prev_q <= 1'b0;
		end else begin
			txc_prev_q <= pins2_q.tx_clock;
		end
	end

	assign tx_rise = pins2_q.tx_clock & ~txc_prev_q;

	// shared lock timer; cleared by sleep or missing supply
	logic [9:0] lock_cnt_q;
	logic       locked_q;
	logic       core_on;

	assign core_on = pins2_q.master_sleep_n & pins2_q.supply_good;

	always_ff @(posedge i_clock) begin
		if (!i_rstn || !core_on) begin
			lock_cnt_q <= 10'h000;
			locked_q   <= 1'b0;
		end else if (tx_rise && !locked_q) begin
			lock_cnt_q <= lock_cnt_q + 10'h001;
			locked_q   <= (lock_cnt_q + 10'h001) == `OSR_LOCK_TX_CYCLES;
		end
	end

	// free-running test pattern, ten steps per transmit cycle
	logic [14:0] prbs_q;
	osr_prbs_t   prbs_next;

	assign prbs_next = osr_prbs_step(prbs_q);

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			prbs_q <= `OSR_PRBS_SEED;
		end else if (tx_rise) begin
			prbs_q <= prbs_next.state;
		end
	end

	logic [7:0] test_mask;
	assign test_mask = osr_test_mask(pins2_q.self_test_activate, pins2_q.self_test_select);

	// software channel mask, ANDed with the sleep pins
	logic [31:0] ctrl_q;

	logic [7:0] ch_on;
	logic [7:0] ch_ready;
	logic [7:0] sync_on;
	osr_frame_t [7:0] frame_q;
	logic [7:0] oe_n_q;
	logic       strobe_q;

	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
			logic [6:0] up_cnt_q;
			logic [2:0] sync_cnt_q;

			assign ch_on[c] = locked_q & pins2_q.channel_sleep_n[c] & ctrl_q[c];
			assign ch_ready[c] = (up_cnt_q == `OSR_CH_UP_TX_CYCLES);
			assign sync_on[c] = (sync_cnt_q == `OSR_SYNC_TX_CYCLES);

			always_ff @(posedge i_clock) begin
				if (!i_rstn || !ch_on[c]) begin
					up_cnt_q <= 7'h00;
				end else if (tx_rise && !ch_ready[c]) begin
					up_cnt_q <= up_cnt_q + 7'h01;
				end
			end

			// falling request clears at once, so data resumes next edge
			always_ff @(posedge i_clock) begin
				if (!i_rstn || !pins2_q.sync_request[c]) begin
					sync_cnt_q <= 3'h0;
				end else if (tx_rise && !sync_on[c]) begin
					sync_cnt_q <= sync_cnt_q + 3'h1;
				end
			end

			always_ff @(posedge i_clock) begin
				if (!i_rstn) begin
					frame_q[c] <= '0;
				end else if (tx_rise) begin
					if (sync_on[c]) begin
						frame_q[c] <= `OSR_SYNC_FRAME;
					end else if (test_mask[c]) begin
						frame_q[c] <= {`OSR_STOP_BIT, prbs_next.bits, `OSR_START_BIT};
					end else begin
						frame_q[c] <= {`OSR_STOP_BIT, word2_q[c], `OSR_START_BIT};
					end
				end
			end

			// state keeps running while floated, so enable returns it unchanged
			always_ff @(posedge i_clock) begin
				if (!i_rstn) begin
					oe_n_q[c] <= 1'b1;
				end else begin
					oe_n_q[c] <= ~(pins2_q.driver_enable & core_on & ch_on[c] & ch_ready[c]);
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= tx_rise;
		end
	end

	assign o_serial_out   = frame_q;
	assign o_serial_oe_n  = oe_n_q;
	assign o_frame_strobe = strobe_q;

	// register slave: one write and one read in flight
	logic        awready_q;
	logic        wready_q;
	logic        aw_got_q;
	logic        w_got_q;
	logic [3:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        wr_fire;
	logic        b_done;
	logic [31:0] status;

	assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
	assign b_done  = bvalid_q & i_s_axi_bready;

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			awready_q <= 1'b0;
			aw_got_q  <= 1'b0;
			awaddr_q  <= 4'h0;
		end else if (i_s_axi_awvalid && awready_q) begin
			awready_q <= 1'b0;
			aw_got_q  <= 1'b1;
			awaddr_q  <= i_s_axi_awaddr;
		end else if (b_done) begin
			aw_got_q  <= 1'b0;
			awready_q <= 1'b1;
		end else if (!aw_got_q) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			wready_q <= 1'b0;
			w_got_q  <= 1'b0;
			wdata_q  <= 32'h00000000;
			wstrb_q  <= 4'h0;
		end else if (i_s_axi_wvalid && wready_q) begin
			wready_q <= 1'b0;
			w_got_q  <= 1'b1;
			wdata_q  <= i_s_axi_wdata;
			wstrb_q  <= i_s_axi_wstrb;
		end else if (b_done) begin
			w_got_q  <= 1'b0;
			wready_q <= 1'b1;
		end else if (!w_got_q) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `OSR_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (osr_decode(awaddr_q) == OSR_REG_NONE) ? `OSR_RESP_SLVERR
				: `OSR_RESP_OKAY;
		end else if (b_done) begin
			bvalid_q <= 1'b0;
		end
	end

	// only the low byte holds the mask; status is read-only
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			ctrl_q <= `OSR_CTRL_RESET;
		end else if (wr_fire && osr_decode(awaddr_q) == OSR_REG_CTRL && wstrb_q[0]) begin
			ctrl_q <= {24'h000000, wdata_q[7:0]};
		end
	end

	always_comb begin
		status = 32'h00000000;
		status[`OSR_ST_LOCKED] = locked_q;
		status[`OSR_ST_LIVE_LSB +: 8] = ~oe_n_q;
		status[`OSR_ST_SYNC_LSB +: 8] = sync_on;
		status[`OSR_ST_TEST] = |test_mask;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `OSR_RESP_OKAY;
		end else if (i_s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			case (osr_decode(i_s_axi_araddr))
				OSR_REG_STATUS: begin
					rdata_q <= status;
					rresp_q <= `OSR_RESP_OKAY;
				end
				OSR_REG_CTRL: begin
					rdata_q <= ctrl_q;
					rresp_q <= `OSR_RESP_OKAY;
				end
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= `OSR_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && i_s_axi_rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	assign o_s_axi_awready = awready_q;
	assign o_s_axi_wready  = wready_q;
	assign o_s_axi_bvalid  = bvalid_q;
	assign o_s_axi_bresp   = bresp_q;
	assign o_s_axi_arready = arready_q;
	assign o_s_axi_rvalid  = rvalid_q;
	assign o_s_axi_rdata   = rdata_q;
	assign o_s_axi_rresp   = rresp_q;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	logic [7:0] framed_ok;
	logic [7:0] sync_ok;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			framed_ok[i] = frame_q[i][0] & ~frame_q[i][11];
			sync_ok[i]   = ~sync_on[i] | (frame_q[i] == `OSR_SYNC_FRAME);
		end
	end
	property p_framing;
		strobe_q |-> &(oe_n_q | framed_ok);
	endproperty
	a_framing: assert property (p_framing) else $error("start or stop bit wrong");
	property p_sync_frame;
		strobe_q && $past(sync_on) == sync_on |-> &sync_ok;
	endproperty
	a_sync_frame: assert property (p_sync_frame) else $error("sync frame wrong");
	property p_data_word;
		tx_rise && !sync_on[0] && !test_mask[0] |=> frame_q[0][10:1] == $past(word2_q[0]);
	endproperty
	a_data_word: assert property (p_data_word) else $error("word not captured");
	property p_den_float;
		!pins2_q.driver_enable |=> &oe_n_q;
	endproperty
	a_den_float: assert property (p_den_float) else $error("outputs driven while disabled");
	property p_sleep;
		!pins2_q.master_sleep_n |=> !locked_q && &oe_n_q;
	endproperty
	a_sleep: assert property (p_sleep) else $error("master sleep ignored");
	property p_lock_count;
		$rose(locked_q) |-> lock_cnt_q == `OSR_LOCK_TX_CYCLES;
	endproperty
	a_lock_count: assert property (p_lock_count) else $error("lock after wrong count");
	property p_test_off;
		!pins2_q.self_test_activate || pins2_q.self_test_select > `OSR_SEL_ALL |-> test_mask == 8'h00;
	endproperty
	a_test_off: assert property (p_test_off) else $error("self-test active wrongly");
	property p_test_all;
		pins2_q.self_test_activate && pins2_q.self_test_select == `OSR_SEL_ALL |-> test_mask == 8'hFF;
	endproperty
	a_test_all: assert property (p_test_all) else $error("self-test not on all");
	property p_prbs;
		tx_rise |=> prbs_q[14:10] == $past(prbs_q[4:0]);
	endproperty
	a_prbs: assert property (p_prbs) else $error("pattern register did not shift");
	property p_sync_delay;
		$rose(sync_on[0]) |-> pins2_q.sync_request[0] && $past(pins2_q.sync_request[0]);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("sync began without request");
	c_lock: cover property ($rose(locked_q));
	c_sync: cover property ($rose(sync_on[0]));
	c_test: cover property (strobe_q && test_mask == 8'hFF);
	c_write: cover property (wr_fire);
endmodule
`default_nettype wire

// ===== logic/osr_map.svh
`ifndef OSR_MAP_SVH
`define OSR_MAP_SVH

`define OSR_LOCK_TX_CYCLES 10'd512
`define OSR_CH_UP_TX_CYCLES 7'd63
`define OSR_SYNC_TX_CYCLES 3'd4
`define OSR_SYNC_FRAME 12'h03F
`define OSR_START_BIT 1'b1
`define OSR_STOP_BIT 1'b0
`define OSR_SEL_ALL 4'h8
`define OSR_SEL_RESET 4'hF
`define OSR_PRBS_SEED 15'h7FFF

`define OSR_ADDR_STATUS 4'h0
`define OSR_ADDR_CTRL 4'h4
`define OSR_CTRL_RESET 32'h000000FF
`define OSR_ST_LOCKED 0
`define OSR_ST_LIVE_LSB 8
`define OSR_ST_SYNC_LSB 16
`define OSR_ST_TEST 24
`define OSR_RESP_OKAY 2'h0
`define OSR_RESP_SLVERR 2'h2

`endif

// ===== logic/osr_pkg.sv
`default_nettype none
package osr_pkg;
	typedef logic [9:0] osr_word_t;
	typedef logic [11:0] osr_frame_t;
	typedef struct packed {
		logic       tx_clock;
		logic       driver_enable;
		logic       master_sleep_n;
		logic       supply_good;
		logic       self_test_activate;
		logic [3:0] self_test_select;
		logic [7:0] channel_sleep_n;
		logic [7:0] sync_request;
	} osr_pins_t;
	typedef struct packed {
		logic [14:0] state;
		logic [9:0]  bits;
	} osr_prbs_t;
	typedef enum {OSR_REG_STATUS, OSR_REG_CTRL, OSR_REG_NONE} osr_reg_t;
endpackage
`default_nettype wire

// ===== verif/osr_source.sv
`default_nettype none
module osr_source (
	input  wire logic                i_clock,
	input  wire osr_pkg::osr_word_t  i_base,
	output logic                     o_tx_clock,
	output osr_pkg::osr_word_t [7:0] o_words
);
	timeunit 1ns;
	timeprecision 1ns;
	import osr_pkg::*;
	logic [2:0]      cnt_q = 3'h0;
	osr_word_t [7:0] words_q = '0;

	// free-running reference, eight system cycles a period
	assign o_tx_clock = cnt_q[2];
	assign o_words = words_q;

	always @(posedge i_clock) begin
		cnt_q <= cnt_q + 3'h1;
	end

	// words move on the falling tx edge, half a period clear of capture
	// all ten bits used; a narrower source pins D0 high, D9 low
	always @(posedge i_clock) begin
		if (cnt_q == 3'h7) begin
			for (int c = 0; c < 8; c++) begin
				words_q[c] <= i_base + 10'(c);
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb.sv
`include "osr_map.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import osr_pkg::*;
	logic             clk = 1'h0;
	logic             rstn;
	osr_pins_t        pq;
	osr_pins_t        pins;
	logic             tx;
	osr_word_t        base;
	osr_word_t [7:0]  words;
	osr_frame_t [7:0] fo;
	logic [7:0]       oe_n;
	logic             stb;
	logic [3:0]       awaddr, araddr, wstrb;
	logic [31:0]      wdata, rdata, d;
	logic             awvalid, wvalid, bready, arvalid, rready;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [1:0]       bresp, rresp, r;
	int               n_mismatch;
	int               checked;

	always #25 clk = ~clk;

	always_comb begin
		pins = pq;
		pins.tx_clock = tx;
	end

	osr_source u_src (.i_clock(clk), .i_base(base), .o_tx_clock(tx), .o_words(words));

	osr_serializer u_dut (
		.i_clock(clk), .i_rstn(rstn), .i_pins(pins), .i_parallel_word_in(words),
		.o_serial_out(fo), .o_serial_oe_n(oe_n), .o_frame_strobe(stb),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready)
	);

	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task conclude;
		$display("mismatches=%0d checks=%0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// framed data word: stop, payload, start in bit 0
	function automatic logic [31:0] fr(input int c);
		return 32'({1'h0, osr_word_t'(base + 10'(c)), 1'h1});
	endfunction

	task frames(input logic [7:0] m);
		for (int c = 0; c < 8; c++)
			if (m[c])
				chk(32'(fo[c]), fr(c));
	endtask

	task wait_oe(input logic [7:0] e);
		for (int i = 0; i < 6000 && oe_n !== e; i++)
			@(posedge clk);
		chk(32'(oe_n), 32'(e));
	endtask

	// a fresh edge first, so a release and the next request never share a time step
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		r = bresp;
	endtask

	task rd(input logic [3:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		d = rdata;
		r = rresp;
	endtask

	task t_init;
		int n;
		cyc(800);
		chk(32'(oe_n), 32'hFF);
		pq.supply_good <= 1'h1;
		wait_oe(8'h00);
		cyc(40);
		frames(8'hFF);
		base <= 10'h0C6;
		cyc(40);
		frames(8'hFF);
		n = 0;
		repeat (80) begin
			@(posedge clk);
			n += int'(stb);
		end
		chk(32'(n), 32'hA);
	endtask

	task t_regs;
		rd(`OSR_ADDR_STATUS);
		chk(32'(d[0]), 32'h1);
		chk(32'(d[15:8]), 32'hFF);
		rd(`OSR_ADDR_CTRL);
		chk(d, 32'hFF);
		wr(`OSR_ADDR_CTRL, 32'h0F);
		chk(32'(r), 32'h0);
		rd(`OSR_ADDR_CTRL);
		chk(d, 32'h0F);
		chk(32'(oe_n), 32'hF0);
		wr(`OSR_ADDR_CTRL, 32'hFF);
		rd(4'hC);
		chk(d, 32'h0);
		chk(32'(r), 32'h2);
		wr(4'h8, 32'h0);
		chk(32'(r), 32'h2);
		wait_oe(8'h00);
	endtask

	// too few tx edges yet for sync, then sync, then back to data
	task t_sync;
		pq.sync_request <= 8'h08;
		cyc(16);
		chk(32'(fo[3]), fr(3));
		cyc(40);
		chk(32'(fo[3]), 32'h03F);
		frames(8'hF7);
		rd(`OSR_ADDR_STATUS);
		chk(32'(d[23:16]), 32'h08);
		pq.sync_request <= 8'h00;
		cyc(24);
		frames(8'hFF);
	endtask

	task t_sleep;
		pq.channel_sleep_n <= 8'hFB;
		cyc(8);
		chk(32'(oe_n), 32'h04);
		pq.channel_sleep_n <= 8'hFF;
		cyc(400);
		chk(32'(oe_n), 32'h04);
		wait_oe(8'h00);
		cyc(16);
		frames(8'hFF);
	endtask

	task t_den;
		pq.driver_enable <= 1'h0;
		cyc(8);
		chk(32'(oe_n), 32'hFF);
		pq.driver_enable <= 1'h1;
		cyc(8);
		chk(32'(oe_n), 32'h00);
		frames(8'hFF);
	endtask

	// every select code with activate high, then code eight with it low
	task t_test;
		for (int s = 0; s < 17; s++) begin
			pq.self_test_activate <= 1'(s < 16);
			pq.self_test_select <= 4'(s < 16 ? s : 8);
			cyc(120);
			for (int c = 0; c < 8; c++) begin
				chk(32'(fo[c] !== 12'(fr(c))), 32'(s == c || s == 8));
				chk(32'({fo[c][11], fo[c][0]}), 32'h1);
			end
		end
		pq.self_test_activate <= 1'h0;
		pq.self_test_select <= 4'hF;
	endtask

	task t_master;
		pq.master_sleep_n <= 1'h0;
		cyc(8);
		chk(32'(oe_n), 32'hFF);
		rd(`OSR_ADDR_STATUS);
		chk(32'(d[0]), 32'h0);
		pq.master_sleep_n <= 1'h1;
		cyc(800);
		chk(32'(oe_n), 32'hFF);
		wait_oe(8'h00);
	endtask

	initial begin
		rstn = 1'h0;
		pq = '0;
		pq.driver_enable = 1'h1;
		pq.master_sleep_n = 1'h1;
		pq.channel_sleep_n = 8'hFF;
		pq.self_test_select = 4'hF;
		base = 10'h1A5;
		{awaddr, araddr, wstrb, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		cyc(20);
		rstn <= 1'h1;
		cyc(2);
		t_init;
		t_regs;
		t_sync;
		t_sleep;
		t_den;
		t_test;
		t_master;
		conclude;
	end

	// whole run needs about 13500 cycles
	initial begin
		cyc(40000);
		n_mismatch++;
		conclude;
	end
endmodule
`default_nettype wire
